// file: can_node_model.sv
// Far-side model: nonvolatile address store and a CAN node that answers forwarded requests.
`timescale 1ns/10ps
module can_node_model
  import motor_node_pkg::*;
#(
  parameter logic [7:0] NV_INIT = 8'h07
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Reply pacing
  input  wire logic [3:0]  reply_wait,
  // CAN side
  input  wire command_type can_req,
  output byte_type         can_reply,
  // Storage side
  input  wire byte_type    nv_write,
  output logic      [7:0]  nv_can_addr
);
  logic [3:0] wait_count;
  logic       pending;
  logic [7:0] reply_data;

  initial begin
    nv_can_addr = NV_INIT;
    can_reply   = '0;
    pending     = 1'b0;
    wait_count  = '0;
    reply_data  = '0;
  end

  always @(posedge core_clk) begin
    if (nv_write.valid) begin
      nv_can_addr <= nv_write.data;
    end
  end

  // The data lines toggle outside a reply so stale data can never pass for a reply.
  // reply after wait
  always @(posedge core_clk) begin
    can_reply.valid <= 1'b0;
    can_reply.data  <= ~can_reply.data;
    if (rst) begin
      pending <= 1'b0;
    end else if (can_req.valid) begin
      pending    <= 1'b1;
      wait_count <= reply_wait;
      reply_data <= can_req.can_target + 8'h40;
    end else if (pending) begin
      if (wait_count == 4'h0) begin
        pending   <= 1'b0;
        can_reply <= '{valid: 1'b1, data: reply_data};
      end else begin
        wait_count <= wait_count - 4'h1;
      end
    end
  end
endmodule // can_node_model

// file: interval_timer.sv
// Free-running interval counter with a tick pulse and a sticky expiry flag.
`timescale 1ns/10ps
module interval_timer #(
  parameter int CYCLES = 16
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Status
  output logic      tick,
  output logic      expired
);
  localparam int W = $clog2(CYCLES) + 1;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] count;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count == LAST) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + W'(1);
      tick  <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      expired <= 1'b0;
    end else if (tick) begin
      expired <= 1'b1;
    end
  end
endmodule // interval_timer

// file: motor_node.sv
// Motor node: status lamps, serial address filter, echo and CAN forwarding.
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/10ps

// Notes on behaviour
// RULE1: fault at power-up: fault lamp steady red
// RULE2: sealed faults low, connector faults high
// RULE3: otherwise red 500 ms, then flashing green
// RULE4: busy flag follows active trajectory
// RULE5: CAN ok: trajectory lamp off or green
// RULE6: CAN fault, idle: trajectory lamp flashes red
// RULE7: CAN fault, busy: red/green alternate
// RULE8: power-up: no echo, 9600, address 0
// RULE9: no echo means nothing forwarded on
// RULE10: host addresses nodes one by one
// RULE11: execute own address, ignore others
// RULE12: global address zero reaches every node
// RULE13: serial address volatile, applies at once
// RULE14: system reset clears serial address
// RULE15: CAN address stored, applies after reset
// RULE16: copy serial address into CAN address
// RULE17: global restore serial from CAN address
// RULE18: colon suffix selects CAN target node
// RULE19: forward over CAN, relay reply back
// RULE20: host pre-addresses bus-only nodes singly
// RULE21: blink period fixed, clock derived
module motor_node
  import motor_node_pkg::*;
#(
  parameter int STARTUP_TICKS = STARTUP_CYCLES,
  parameter int BLINK_TICKS   = BLINK_CYCLES
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Travel limit pins
  input  wire logic        limit_pos_pin,
  input  wire logic        limit_neg_pin,
  // Motion core and CAN controller status
  input  wire logic        traj_active,
  input  wire logic        can_bus_fault,
  // Decoded serial traffic
  input  wire command_type cmd_in,
  input  wire byte_type    rx_byte,
  output byte_type         next_node_tx,
  output command_type      local_exec,
  output byte_type         host_reply,
  output logic      [15:0] baud_div,
  // CAN side
  output command_type      can_req,
  input  wire byte_type    can_reply,
  output logic      [7:0]  can_node_address,
  // Nonvolatile storage
  input  wire logic [7:0]  nv_can_addr,
  output byte_type         nv_write,
  // Lamps and flags
  output lamp_type         fault_status_lamp,
  output lamp_type         trajectory_lamp,
  output logic             trajectory_busy_flag
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] limit_meta;
  logic [1:0] limit_sync;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      limit_meta <= '0;
      limit_sync <= '0;
    end else begin
      limit_meta <= {limit_pos_pin, limit_neg_pin};
      limit_sync <= limit_meta;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  logic [CTRL_W-1:0] ctrl;
  logic [7:0]        serial_node_address;
  logic              echo_on;
  logic              asleep;
  logic              load_pending;
  logic              limit_fault;
  logic              show_fault;
  lamp_state_type    lamp_state;
  logic [STAT_W-1:0] status;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl <= CTRL_INIT;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      ctrl <= reg_wdata[CTRL_W-1:0];
    end
  end

  always_comb begin
    status               = '0;
    status[STAT_BUSY]    = trajectory_busy_flag;
    status[STAT_ECHO]    = echo_on;
    status[STAT_SLEEP]   = asleep;
    status[STAT_LIMIT]   = limit_fault;
    status[STAT_CAN]     = can_bus_fault;
    status[STAT_STARTUP] = (lamp_state != st_hold_red);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:        reg_rdata <= 32'(ctrl);
        REG_STATUS:      reg_rdata <= 32'(status);
        REG_SERIAL_ADDR: reg_rdata <= 32'(serial_node_address);
        REG_CAN_ADDR:    reg_rdata <= 32'(can_node_address);
        default:         reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // ****************************************
  // Command filter
  // ****************************************
  logic hit;
  logic run_local;
  logic run_can;

  // RULE11 RULE12 address filter
  assign hit = cmd_in.valid && (cmd_in.serial_target == serial_node_address
                                || cmd_in.serial_target == GLOBAL_ADDR);
  // RULE18 colon target select
  assign run_can   = hit && cmd_in.to_can;
  assign run_local = hit && !cmd_in.to_can;

  function automatic logic is_op(input opcode_type op);
    return run_local && cmd_in.opcode == op;
  endfunction

  // RULE8 RULE13 RULE14 serial address
  always_ff @(posedge core_clk) begin
    if (rst || is_op(op_system_reset)) begin
      serial_node_address <= SERIAL_ADDR_INIT;
    end else if (is_op(op_set_addr)) begin
      serial_node_address <= cmd_in.value;
    end else if (is_op(op_addr_from_can_node_address)) begin
      // RULE17 restore from stored
      serial_node_address <= nv_can_addr;
    end else if (reg_wr && reg_addr == REG_SERIAL_ADDR) begin
      serial_node_address <= reg_wdata[7:0];
    end
  end

  // RULE8 RULE10 echo, sleep and rate
  always_ff @(posedge core_clk) begin
    if (rst || is_op(op_system_reset)) begin
      echo_on  <= 1'b0;
      asleep   <= 1'b0;
      baud_div <= BAUD_DIV;
    end else begin
      if (is_op(op_echo_on)) begin
        echo_on <= 1'b1;
      end else if (is_op(op_echo_off)) begin
        echo_on <= 1'b0;
      end
      if (is_op(op_sleep)) begin
        asleep <= 1'b1;
      end else if (is_op(op_wake)) begin
        asleep <= 1'b0;
      end
    end
  end

  // RULE9 echo gating
  always_ff @(posedge core_clk) begin
    if (rst) begin
      next_node_tx <= '0;
    end else begin
      next_node_tx.valid <= rx_byte.valid && echo_on;
      next_node_tx.data  <= rx_byte.data;
    end
  end

  // ****************************************
  // Execution and CAN forwarding
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      local_exec <= '0;
    end else begin
      local_exec       <= cmd_in;
      local_exec.valid <= run_local;
    end
  end

  // RULE19 forward over CAN
  always_ff @(posedge core_clk) begin
    if (rst) begin
      can_req <= '0;
    end else begin
      can_req       <= cmd_in;
      can_req.valid <= run_can;
    end
  end

  // RULE19 relay CAN reply
  always_ff @(posedge core_clk) begin
    if (rst) begin
      host_reply <= '0;
    end else begin
      host_reply <= can_reply;
    end
  end

  // ****************************************
  // CAN node address
  // ****************************************
  // RULE16 copy into storage
  always_ff @(posedge core_clk) begin
    if (rst) begin
      nv_write <= '0;
    end else if (is_op(op_can_node_address_from_addr)) begin
      nv_write.valid <= 1'b1;
      nv_write.data  <= serial_node_address;
    end else if (is_op(op_set_can_node_address)) begin
      nv_write.valid <= 1'b1;
      nv_write.data  <= cmd_in.value;
    end else if (reg_wr && reg_addr == REG_CAN_ADDR) begin
      nv_write.valid <= 1'b1;
      nv_write.data  <= reg_wdata[7:0];
    end else begin
      nv_write.valid <= 1'b0;
    end
  end

  // The stored value is taken only after a reset, never on a write.
  // RULE15 apply after restart
  always_ff @(posedge core_clk) begin
    if (rst) begin
      load_pending <= 1'b1;
    end else if (is_op(op_system_reset)) begin
      load_pending <= 1'b1;
    end else begin
      load_pending <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      can_node_address <= '0;
    end else if (load_pending) begin
      can_node_address <= nv_can_addr;
    end
  end

  // ****************************************
  // Fault lamp
  // ****************************************
  logic startup_done;
  logic blink_tick;
  logic blink_phase;

  // RULE3 startup red period
  interval_timer #(.CYCLES(STARTUP_TICKS)) startup_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (),
    .expired  (startup_done)
  );

  // RULE21 fixed blink rate
  interval_timer #(.CYCLES(BLINK_TICKS)) blink_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (blink_tick),
    .expired  ()
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      blink_phase <= 1'b0;
    end else if (blink_tick) begin
      blink_phase <= !blink_phase;
    end
  end

  // RULE2 variant fault level
  always_comb begin
    if (ctrl[CTRL_SEALED]) begin
      limit_fault = !limit_sync[1] || !limit_sync[0];
    end else begin
      limit_fault = limit_sync[1] || limit_sync[0];
    end
  end

  // A program that switches limits off hides the limit fault.
  assign show_fault = limit_fault
    && !(ctrl[CTRL_PROGRAM] && ctrl[CTRL_LIMITS_OFF]);

  // RULE1 RULE3 lamp sequence
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lamp_state <= st_hold_red;
    end else begin
      case (lamp_state)
        st_hold_red: begin
          if (show_fault) begin
            lamp_state <= st_show_fault;
          end else if (startup_done) begin
            lamp_state <= st_ready;
          end
        end
        st_show_fault: begin
          if (!show_fault) begin
            lamp_state <= startup_done ? st_ready : st_hold_red;
          end
        end
        st_ready: begin
          if (show_fault) begin
            lamp_state <= st_show_fault;
          end
        end
        default: lamp_state <= st_hold_red;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fault_status_lamp <= LAMP_RED;
    end else if (lamp_state == st_ready) begin
      fault_status_lamp <= blink_phase ? LAMP_GREEN : LAMP_OFF;
    end else begin
      fault_status_lamp <= LAMP_RED;
    end
  end

  // ****************************************
  // Trajectory lamp
  // ****************************************
  // RULE4 busy flag
  always_ff @(posedge core_clk) begin
    if (rst) begin
      trajectory_busy_flag <= 1'b0;
    end else begin
      trajectory_busy_flag <= traj_active;
    end
  end

  // RULE5 RULE6 RULE7 lamp colour
  always_ff @(posedge core_clk) begin
    if (rst) begin
      trajectory_lamp <= LAMP_OFF;
    end else if (!can_bus_fault) begin
      trajectory_lamp <= trajectory_busy_flag ? LAMP_GREEN : LAMP_OFF;
    end else if (!trajectory_busy_flag) begin
      trajectory_lamp <= blink_phase ? LAMP_RED : LAMP_OFF;
    end else begin
      trajectory_lamp <= blink_phase ? LAMP_RED : LAMP_GREEN;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_hold_then_ready;
    lamp_state == st_hold_red ##1 lamp_state == st_ready;
  endsequence

  property p_fault_steady;
    @(posedge core_clk) disable iff (rst)
    lamp_state == st_show_fault |=> fault_status_lamp == LAMP_RED;
  endproperty
  a_fault_steady: assert property (p_fault_steady) // RULE1
    else $error("Fault lamp not red during fault.");

  property p_sealed_low;
    @(posedge core_clk) disable iff (rst)
    ctrl[CTRL_SEALED] && !ctrl[CTRL_PROGRAM] && limit_sync == 2'h0
      |-> show_fault;
  endproperty
  a_sealed_low: assert property (p_sealed_low) // RULE2
    else $error("Low limit not a fault on sealed variant.");

  property p_ready_after_wait;
    @(posedge core_clk) disable iff (rst)
    s_hold_then_ready |-> $past(startup_done) ##1 fault_status_lamp.red == 1'b0;
  endproperty
  a_ready_after_wait: assert property (p_ready_after_wait) // RULE3
    else $error("Green flashing began before the red period ended.");

  property p_traj_green;
    @(posedge core_clk) disable iff (rst)
    !can_bus_fault && trajectory_busy_flag |=> trajectory_lamp == LAMP_GREEN;
  endproperty
  a_traj_green: assert property (p_traj_green) // RULE5
    else $error("Trajectory lamp not green while busy.");

  property p_traj_flash_red;
    @(posedge core_clk) disable iff (rst)
    can_bus_fault && !trajectory_busy_flag
      |=> !trajectory_lamp.green && trajectory_lamp.red == $past(blink_phase);
  endproperty
  a_traj_flash_red: assert property (p_traj_flash_red) // RULE6
    else $error("Trajectory lamp not flashing red on bus fault.");

  property p_traj_alternate;
    @(posedge core_clk) disable iff (rst)
    can_bus_fault && trajectory_busy_flag
      |=> trajectory_lamp.red != trajectory_lamp.green;
  endproperty
  a_traj_alternate: assert property (p_traj_alternate) // RULE7
    else $error("Trajectory lamp not alternating.");

  property p_echo_gate;
    @(posedge core_clk) disable iff (rst)
    rx_byte.valid && !echo_on |=> !next_node_tx.valid;
  endproperty
  a_echo_gate: assert property (p_echo_gate) // RULE9
    else $error("Byte forwarded while echo is off.");

  property p_addr_filter;
    @(posedge core_clk) disable iff (rst)
    cmd_in.valid && cmd_in.serial_target != serial_node_address
      && cmd_in.serial_target != GLOBAL_ADDR
      |=> !local_exec.valid && !can_req.valid;
  endproperty
  a_addr_filter: assert property (p_addr_filter) // RULE11
    else $error("Command for another node was taken.");

  property p_reset_cmd;
    @(posedge core_clk) disable iff (rst)
    run_local && cmd_in.opcode == op_system_reset
      |=> serial_node_address == SERIAL_ADDR_INIT && !echo_on
      ##1 can_node_address == $past(nv_can_addr);
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) // RULE14
    else $error("System reset did not restore addresses.");

  property p_can_node_address_copy;
    @(posedge core_clk) disable iff (rst)
    run_local && cmd_in.opcode == op_can_node_address_from_addr
      |=> nv_write.valid && nv_write.data == $past(serial_node_address);
  endproperty
  a_can_node_address_copy: assert property (p_can_node_address_copy) // RULE16
    else $error("Serial address not copied to storage.");

  property p_relay;
    @(posedge core_clk) disable iff (rst)
    can_reply.valid |=> host_reply.valid && host_reply.data == $past(can_reply.data);
  endproperty
  a_relay: assert property (p_relay) // RULE19
    else $error("CAN reply not relayed to host.");

endmodule // motor_node

// file: motor_node_pkg.sv
// Shared constants and types for the motor node addressing and lamp block.
package motor_node_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ         = 100_000_000;
  localparam int STARTUP_RED_MS = 500;
  localparam int STARTUP_CYCLES = STARTUP_RED_MS * (CLK_HZ / 1000);
  localparam int BLINK_HALF_MS  = 250;
  localparam int BLINK_CYCLES   = BLINK_HALF_MS * (CLK_HZ / 1000);
  localparam int BAUD_RATE      = 9600;
  localparam logic [15:0] BAUD_DIV = 16'(CLK_HZ / BAUD_RATE);

  // ****************************************
  // Addresses and reset values
  // ****************************************
  localparam logic [7:0] GLOBAL_ADDR      = 8'h00;
  localparam logic [7:0] SERIAL_ADDR_INIT = 8'h00;
  localparam logic [2:0] CTRL_INIT        = 3'h0;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] REG_CTRL        = 4'h0;
  localparam logic [3:0] REG_STATUS      = 4'h4;
  localparam logic [3:0] REG_SERIAL_ADDR = 4'h8;
  localparam logic [3:0] REG_CAN_ADDR    = 4'hc;

  localparam int CTRL_PROGRAM    = 0;
  localparam int CTRL_LIMITS_OFF = 1;
  localparam int CTRL_SEALED     = 2;
  localparam int CTRL_W          = 3;

  localparam int STAT_BUSY     = 0;
  localparam int STAT_ECHO     = 1;
  localparam int STAT_SLEEP    = 2;
  localparam int STAT_LIMIT    = 3;
  localparam int STAT_CAN      = 4;
  localparam int STAT_STARTUP  = 5;
  localparam int STAT_W        = 6;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    op_none, op_set_addr, op_echo_on, op_echo_off, op_sleep, op_wake,
    report_position_command, op_can_node_address_from_addr, op_addr_from_can_node_address,
    op_set_can_node_address, op_system_reset
  } opcode_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] serial_target;
    opcode_type opcode;
    logic [7:0] value;
    logic       to_can;
    logic [7:0] can_target;
  } command_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_type;

  typedef struct packed {
    logic red;
    logic green;
  } lamp_type;

  localparam lamp_type LAMP_OFF   = '{red: 1'b0, green: 1'b0};
  localparam lamp_type LAMP_RED   = '{red: 1'b1, green: 1'b0};
  localparam lamp_type LAMP_GREEN = '{red: 1'b0, green: 1'b1};

  typedef enum {st_hold_red, st_show_fault, st_ready} lamp_state_type;

endpackage

// file: test_motor_node.sv
// Self-checking bench for the motor node lamps, address filter and CAN relay.
`timescale 1ns/10ps
module test_motor_node
  import motor_node_pkg::*;
;
  logic        core_clk, rst, reg_wr, reg_rd, limit_pos_pin, limit_neg_pin;
  logic        traj_active, can_bus_fault, trajectory_busy_flag;
  logic [3:0]  reg_addr, reply_wait, m;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [15:0] baud_div;
  logic [7:0]  can_node_address, nv_can_addr;
  command_type cmd_in, local_exec, can_req, le, cr;
  byte_type    rx_byte, next_node_tx, host_reply, can_reply, nv_write, nw, got;
  lamp_type    fault_status_lamp, trajectory_lamp;
  int          err_count, tests_run, cycle_count, n;
  logic [3:0]  exp_mask [4] = '{4'b0001, 4'b0010, 4'b0101, 4'b0110};

  motor_node #(.STARTUP_TICKS(20), .BLINK_TICKS(4)) i_motor_node (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .limit_pos_pin(limit_pos_pin), .limit_neg_pin(limit_neg_pin),
    .traj_active(traj_active), .can_bus_fault(can_bus_fault), .cmd_in(cmd_in),
    .rx_byte(rx_byte), .next_node_tx(next_node_tx), .local_exec(local_exec),
    .host_reply(host_reply), .baud_div(baud_div), .can_req(can_req),
    .can_reply(can_reply), .can_node_address(can_node_address),
    .nv_can_addr(nv_can_addr), .nv_write(nv_write),
    .fault_status_lamp(fault_status_lamp), .trajectory_lamp(trajectory_lamp),
    .trajectory_busy_flag(trajectory_busy_flag));

  can_node_model i_can_node_model (
    .core_clk(core_clk), .rst(rst), .reply_wait(reply_wait), .can_req(can_req),
    .can_reply(can_reply), .nv_write(nv_write), .nv_can_addr(nv_can_addr));

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic send_cmd(input logic [7:0] t, input opcode_type op, input logic [7:0] v,
                          input logic c, input logic [7:0] ct);
    @(posedge core_clk);
    cmd_in <= '{valid: 1'b1, serial_target: t, opcode: op, value: v, to_can: c,
                can_target: ct};
    @(posedge core_clk);
    cmd_in <= '0;
    #1 le = local_exec;
    cr = can_req;
    nw = nv_write;
  endtask

  task automatic send_byte(input logic [7:0] v);
    @(posedge core_clk);
    rx_byte <= '{valid: 1'b1, data: v};
    @(posedge core_clk);
    rx_byte <= '0;
    #1 got = next_node_tx;
  endtask

  // Collects which lamp colours appear: bit 0 off, 1 green, 2 red, 3 both.
  task automatic watch(input int cycles, input logic traj);
    lamp_type l;
    m = 4'h0;
    repeat (cycles) begin
      @(posedge core_clk);
      #1 l = traj ? trajectory_lamp : fault_status_lamp;
      m[{l.red, l.green}] = 1'b1;
    end
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_power_ok();
    repeat (3) @(posedge core_clk);
    #1 chk(fault_status_lamp, LAMP_RED, "startup red");
    repeat (30) @(posedge core_clk);
    watch(20, 1'b0);
    chk(m, 4'b0011, "green flash");
    watch(8, 1'b1);
    chk(m, 4'b0001, "traj lamp off");
    chk(baud_div, 16'h28b0, "baud");
    reg_read(REG_SERIAL_ADDR, d);
    chk(d, 32'h0, "serial addr");
    reg_read(REG_STATUS, d);
    chk(d[STAT_ECHO], 1'b0, "echo off");
    chk(can_node_address, 8'h07, "can addr");
    reg_read(4'h2, d);
    chk(d, 32'h0, "unmapped");
  endtask

  task automatic t_limit_fault();
    @(posedge core_clk) limit_pos_pin <= 1'b1;
    do_reset();
    watch(40, 1'b0);
    chk(m, 4'b0100, "steady red");
    watch(4, 1'b1);
    chk(m, 4'b0001, "traj off");
    reg_read(REG_STATUS, d);
    chk(d[STAT_LIMIT], 1'b1, "high fault");
    @(posedge core_clk) limit_neg_pin <= 1'b1;
    reg_write(REG_CTRL, 32'h4);
    repeat (5) @(posedge core_clk);
    reg_read(REG_STATUS, d);
    chk(d[STAT_LIMIT], 1'b0, "sealed high ok");
    @(posedge core_clk) {limit_pos_pin, limit_neg_pin} <= 2'b00;
    repeat (5) @(posedge core_clk);
    reg_read(REG_STATUS, d);
    chk(d[STAT_LIMIT], 1'b1, "sealed low fault");
    reg_write(REG_CTRL, 32'h0);
  endtask

  task automatic t_limits_off();
    @(posedge core_clk) limit_neg_pin <= 1'b1;
    do_reset();
    reg_write(REG_CTRL, 32'h3);
    repeat (30) @(posedge core_clk);
    watch(20, 1'b0);
    chk(m, 4'b0011, "limits off flash");
    @(posedge core_clk) limit_neg_pin <= 1'b0;
    reg_write(REG_CTRL, 32'h0);
  endtask

  task automatic t_traj();
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      traj_active   <= i[0];
      can_bus_fault <= i[1];
      repeat (4) @(posedge core_clk);
      #1 chk(trajectory_busy_flag, i[0], "busy");
      watch(20, 1'b1);
      chk(m, exp_mask[i], "traj lamp");
    end
    @(posedge core_clk);
    traj_active   <= 1'b0;
    can_bus_fault <= 1'b0;
  endtask

  task automatic t_echo_address();
    send_byte(8'h5a);
    chk(got.valid, 1'b0, "no echo");
    send_cmd(8'h00, op_set_addr, 8'h01, 1'b0, 8'h00);
    reg_read(REG_SERIAL_ADDR, d);
    chk(d, 32'h1, "addr set");
    send_cmd(8'h01, op_echo_on, 8'h00, 1'b0, 8'h00);
    send_cmd(8'h01, op_sleep, 8'h00, 1'b0, 8'h00);
    send_byte(8'ha5);
    chk({got.valid, got.data}, {1'b1, 8'ha5}, "echo");
    reg_read(REG_STATUS, d);
    chk(d[2:1], 2'b11, "echo sleep");
    send_cmd(8'h02, report_position_command, 8'h00, 1'b0, 8'h00);
    chk(le.valid, 1'b0, "other addr");
    send_cmd(8'h01, report_position_command, 8'h00, 1'b0, 8'h00);
    chk({le.valid, le.opcode}, {1'b1, report_position_command}, "own addr");
    send_cmd(8'h00, report_position_command, 8'h00, 1'b0, 8'h00);
    chk(le.valid, 1'b1, "global");
    reg_write(REG_SERIAL_ADDR, 32'h3);
    send_cmd(8'h03, report_position_command, 8'h00, 1'b0, 8'h00);
    chk(le.valid, 1'b1, "new addr");
    send_cmd(8'h01, op_set_addr, 8'h01, 1'b0, 8'h00);
    chk(le.valid, 1'b0, "old addr");
  endtask

  task automatic t_can_addr();
    send_cmd(8'h03, op_set_addr, 8'h01, 1'b0, 8'h00);
    send_cmd(8'h01, op_can_node_address_from_addr, 8'h00, 1'b0, 8'h00);
    chk({nw.valid, nw.data}, {1'b1, 8'h01}, "store");
    repeat (3) @(posedge core_clk);
    chk(can_node_address, 8'h07, "not yet");
    send_cmd(8'h01, op_system_reset, 8'h00, 1'b0, 8'h00);
    repeat (3) @(posedge core_clk);
    chk(can_node_address, 8'h01, "reloaded");
    reg_read(REG_SERIAL_ADDR, d);
    chk(d, 32'h0, "sys reset");
    do_reset();
    reg_read(REG_SERIAL_ADDR, d);
    chk(d, 32'h0, "reboot");
    send_cmd(8'h00, op_addr_from_can_node_address, 8'h00, 1'b0, 8'h00);
    reg_read(REG_SERIAL_ADDR, d);
    chk(d, 32'h1, "restore");
  endtask

  task automatic t_can_forward();
    for (int w = 0; w < 7; w += 6) begin
      @(posedge core_clk) reply_wait <= w[3:0];
      send_cmd(8'h01, report_position_command, 8'h00, 1'b1, 8'h02);
      chk({cr.valid, cr.can_target, le.valid}, {1'b1, 8'h02, 1'b0}, "fwd");
      n = 0;
      while (host_reply.valid !== 1'b1 && n < 20) begin
        @(posedge core_clk);
        #1 n++;
      end
      chk({host_reply.valid, host_reply.data}, {1'b1, 8'h42}, "relay");
    end
    send_cmd(8'h05, report_position_command, 8'h00, 1'b1, 8'h02);
    chk(cr.valid, 1'b0, "fwd other");
  endtask

  task automatic complete_run();
    $display("Checks run: %0d, mismatches: %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************
  // Clock, timeout and main sequence
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == 5000) begin
      err_count++;
      complete_run();
    end
  end

  initial begin
    {rst, reg_wr, reg_rd, limit_pos_pin, limit_neg_pin} = 5'b10000;
    {traj_active, can_bus_fault, reg_addr, reg_wdata, reply_wait} = '0;
    cmd_in      = '0;
    rx_byte     = '0;
    err_count   = 0;
    tests_run   = 0;
    cycle_count = 0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_power_ok();
    t_limit_fault();
    t_limits_off();
    t_traj();
    t_echo_address();
    t_can_addr();
    t_can_forward();
    complete_run();
  end
endmodule // test_motor_node
